// ### adc_regs_pkg.sv
// Shared constants and types for the converter status and mode register bank
package adc_regs_pkg;
  // Clock rates
  localparam int CLK_HZ          = 25_000_000;
  localparam int CONV_CLK_HZ     = 64_000;
  localparam int CONV_DIV_CYCLES = CLK_HZ / CONV_CLK_HZ;
  localparam int CONV_DIV_HALF   = CONV_DIV_CYCLES / 2;

  // Register select codes
  localparam logic [2:0] RS_STATUS = 3'h0;
  localparam logic [2:0] RS_MODE   = 3'h1;

  // Command byte layout
  localparam int CMD_RW_BIT = 6;
  localparam int CMD_RS_LSB = 3;

  // Status register layout and reset values
  localparam int         ST_RDY_BIT          = 7;
  localparam int         ST_ERR_BIT          = 6;
  localparam int         ST_VAR_BIT          = 3;
  localparam logic [7:0] STATUS_RESET_NARROW = 8'h80;
  localparam logic [7:0] STATUS_RESET_WIDE   = 8'h88;

  // Mode register layout and reset value
  localparam int          MODE_OP_LSB   = 13;
  localparam int          MODE_CLK_LSB  = 6;
  localparam int          MODE_RATE_LSB = 0;
  localparam logic [15:0] MODE_RESET    = 16'h000a;
  localparam logic [15:0] MODE_KEEP     = 16'he0cf;

  // Transfer lengths in serial clocks
  localparam logic [4:0] CMD_LEN    = 5'h08;
  localparam logic [4:0] STATUS_LEN = 5'h08;
  localparam logic [4:0] MODE_LEN   = 5'h10;

  // Clock source codes
  localparam logic [1:0] CLK_SRC_INT      = 2'h0;
  localparam logic [1:0] CLK_SRC_INT_OUT  = 2'h1;
  localparam logic [1:0] CLK_SRC_EXT      = 2'h2;
  localparam logic [1:0] CLK_SRC_EXT_DIV2 = 2'h3;

  // Operating mode codes
  localparam logic [2:0] OP_CONTINUOUS = 3'h0;
  localparam logic [2:0] OP_POWER_DOWN = 3'h3;

  typedef enum logic [3:0] {
    ST_CMD   = 4'h1,
    ST_READ  = 4'h2,
    ST_WRITE = 4'h4,
    ST_PASS  = 4'h8
  } serial_state_t;
endpackage

// ### conv_clock_gen.sv
// Conversion clock enable generator with internal divider and external clock path
`timescale 1ns/1ps
module conv_clock_gen (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] clock_source_field,
  input  wire logic       clk_pin_in,
  output logic            conv_tick,
  output logic            clk_pin_out,
  output logic            clk_pin_oe
);
  logic [8:0] div_cnt;
  logic       ext_q;
  logic       ext_phase;
  logic       ext_rise;
  logic       int_tick;

  assign ext_rise = clk_pin_in & ~ext_q;
  assign int_tick = (div_cnt == 9'(adc_regs_pkg::CONV_DIV_CYCLES - 1));

  // Free running divider for the on-chip 64 kHz rate
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt <= 9'h000;
    end else if (int_tick) begin
      div_cnt <= 9'h000;
    end else begin
      div_cnt <= div_cnt + 9'h001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_pin_out <= 1'b0;
      clk_pin_oe  <= 1'b0;
    end else begin
      clk_pin_out <= (div_cnt < 9'(adc_regs_pkg::CONV_DIV_HALF));
      clk_pin_oe  <= (clock_source_field == adc_regs_pkg::CLK_SRC_INT_OUT);
    end
  end

  // Edge history of the shared external clock; pin is synchronous to clk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_q     <= 1'b0;
      ext_phase <= 1'b0;
    end else begin
      ext_q <= clk_pin_in;
      if (ext_rise) begin
        ext_phase <= ~ext_phase;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_tick <= 1'b0;
    end else begin
      unique case (clock_source_field)
        adc_regs_pkg::CLK_SRC_INT,
        adc_regs_pkg::CLK_SRC_INT_OUT: conv_tick <= int_tick;
        adc_regs_pkg::CLK_SRC_EXT:     conv_tick <= ext_rise;
        adc_regs_pkg::CLK_SRC_EXT_DIV2: conv_tick <= ext_rise & ext_phase;
      endcase
    end
  end
endmodule

// ### adc_status_mode_registers.sv
// Serial status and mode register bank of the sigma-delta converter
//
// Behaviour
// - 8-bit read-only status register, select code 0 on read, reset default.
// - Status register is shifted out most significant bit first.
// - Ready bit goes low when a new result enters the data register.
// - Ready bit sets after a data read and shortly before each update.
// - Ready bit sets on entry to power-down mode.
// - Data-out pin also shows the ready state as end of conversion.
// - Error bit updates with ready, set when the result was clamped.
// - Error bit clears on a register write that starts a conversion.
// - Status bits 5 and 4 always read zero.
// - Status bit 3 shows the wide variant; resets 0x80 or 0x88.
// - Status bits 2 to 0 show the converting channel, reset zero.
// - 16-bit read/write mode register, select code 1, resets to 0x000a.
// - Mode register moves most significant bit first both ways.
// - Mode write resets modulator and filter and sets ready.
// - Mode bits 15 to 13 hold operating mode, reset zero.
// - Mode bits 7 and 6 select the conversion clock source, reset zero.
// - External clock source lets several converters share one clock.
// - Operating mode code zero means continuous conversion.
// - Code 00 internal clock undriven; code 01 drives it on pin.
// - Code 11 takes external clock and halves it.
`timescale 1ns/1ps
module adc_status_mode_registers #(
  parameter logic wide_variant = 1'b0
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       din,
  output logic            dout_rdy,
  output logic            dout_rdy_oe,
  input  wire logic       clk_pin_in,
  output logic            clk_pin_out,
  output logic            clk_pin_oe,
  input  wire logic       result_load,
  input  wire logic       result_clamped,
  input  wire logic       pre_update,
  input  wire logic       data_read_done,
  input  wire logic [2:0] converter_channel,
  input  wire logic       pass_done,
  output logic            other_access,
  output logic [2:0]      other_select,
  output logic            other_read,
  output logic [2:0]      operating_mode_field,
  output logic [1:0]      clock_source_field,
  output logic [3:0]      update_rate_field,
  output logic            continuous_mode,
  output logic            power_down,
  output logic            filter_reset,
  output logic            conv_tick
);
  adc_regs_pkg::serial_state_t state;

  logic        sclk_q;
  logic        sclk_rise;
  logic        sclk_fall;
  logic [4:0]  bit_cnt;
  logic [4:0]  xfer_len;
  logic [6:0]  cmd_shift;
  logic [7:0]  next_cmd;
  logic [15:0] shift;
  logic [15:0] write_word;
  logic        cmd_done;
  logic        xfer_last;
  logic        mode_write_stb;
  logic        pd_enter;
  logic        rdy_set;
  logic        rdy;
  logic        err;
  logic [2:0]  active_channel_field;
  logic [7:0]  status_word;
  logic [15:0] mode_word;

  // Status byte assembly; reserved bits are constant zero
  function automatic logic [7:0] pack_status(input logic r, input logic e,
                                             input logic w, input logic [2:0] ch);
    logic [7:0] s;
    s = 8'h00;
    s[adc_regs_pkg::ST_RDY_BIT] = r;
    s[adc_regs_pkg::ST_ERR_BIT] = e;
    s[adc_regs_pkg::ST_VAR_BIT] = w;
    s[2:0] = ch;
    return s;
  endfunction

  assign status_word = pack_status(rdy, err, wide_variant, active_channel_field);

  // Mode word as read back; unused bits read zero
  assign mode_word = {operating_mode_field, 5'h00, clock_source_field, 2'h0,
                      update_rate_field};

  // Serial clock edges; pins are taken as synchronous to clk
  assign sclk_rise = sclk & ~sclk_q;
  assign sclk_fall = ~sclk & sclk_q;
  assign next_cmd   = {cmd_shift, din};
  assign write_word = {shift[14:0], din};
  assign cmd_done   = ~cs_n && (state == adc_regs_pkg::ST_CMD) && sclk_rise &&
                      (bit_cnt == adc_regs_pkg::CMD_LEN - 5'h01);
  assign xfer_last  = sclk_rise && (bit_cnt == xfer_len - 5'h01);

  // mode word captured on the last write clock
  assign mode_write_stb = ~cs_n && (state == adc_regs_pkg::ST_WRITE) && xfer_last;

  assign pd_enter = mode_write_stb &&
                    (write_word[15:adc_regs_pkg::MODE_OP_LSB] == adc_regs_pkg::OP_POWER_DOWN) &&
                    (operating_mode_field != adc_regs_pkg::OP_POWER_DOWN);
  assign rdy_set = data_read_done | pre_update | pd_enter | mode_write_stb;

  // Serial clock history
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b1;
    end else begin
      sclk_q <= sclk;
    end
  end

  // Serial state machine; chip select high returns to command phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state     <= adc_regs_pkg::ST_CMD;
      bit_cnt   <= 5'h00;
      xfer_len  <= adc_regs_pkg::CMD_LEN;
      cmd_shift <= 7'h00;
      shift     <= 16'h0000;
    end else if (cs_n) begin
      state   <= adc_regs_pkg::ST_CMD;
      bit_cnt <= 5'h00;
    end else begin
      unique case (state)
        adc_regs_pkg::ST_CMD: begin
          // leading ones held at the first bit
          if (sclk_rise && !(bit_cnt == 5'h00 && din)) begin
            cmd_shift <= next_cmd[6:0];
            bit_cnt   <= bit_cnt + 5'h01;
          end
          if (cmd_done) begin
            bit_cnt <= 5'h00;
            if (next_cmd[adc_regs_pkg::CMD_RS_LSB +: 3] == adc_regs_pkg::RS_STATUS) begin
              if (next_cmd[adc_regs_pkg::CMD_RW_BIT]) begin
                state    <= adc_regs_pkg::ST_READ;
                xfer_len <= adc_regs_pkg::STATUS_LEN;
                shift    <= {status_word, 8'h00};
              end
            end else if (next_cmd[adc_regs_pkg::CMD_RS_LSB +: 3] ==
                         adc_regs_pkg::RS_MODE) begin
              xfer_len <= adc_regs_pkg::MODE_LEN;
              shift    <= mode_word;
              if (next_cmd[adc_regs_pkg::CMD_RW_BIT]) begin
                state <= adc_regs_pkg::ST_READ;
              end else begin
                state <= adc_regs_pkg::ST_WRITE;
              end
            end else begin
              state <= adc_regs_pkg::ST_PASS;
            end
          end
        end
        adc_regs_pkg::ST_READ: begin
          // advance towards the next lower bit
          if (sclk_rise) begin
            shift   <= {shift[14:0], 1'b0};
            bit_cnt <= bit_cnt + 5'h01;
          end
          if (xfer_last) begin
            state   <= adc_regs_pkg::ST_CMD;
            bit_cnt <= 5'h00;
          end
        end
        adc_regs_pkg::ST_WRITE: begin
          if (sclk_rise) begin
            shift   <= write_word;
            bit_cnt <= bit_cnt + 5'h01;
          end
          if (xfer_last) begin
            state   <= adc_regs_pkg::ST_CMD;
            bit_cnt <= 5'h00;
          end
        end
        adc_regs_pkg::ST_PASS: begin
          // Other registers are served elsewhere until they hand back
          if (pass_done) begin
            state <= adc_regs_pkg::ST_CMD;
          end
        end
      endcase
    end
  end

  // Hand-off of selections for registers outside this bank
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      other_access <= 1'b0;
      other_select <= 3'h0;
      other_read   <= 1'b0;
    end else begin
      other_access <= cmd_done &&
                      (next_cmd[adc_regs_pkg::CMD_RS_LSB +: 3] != adc_regs_pkg::RS_STATUS) &&
                      (next_cmd[adc_regs_pkg::CMD_RS_LSB +: 3] != adc_regs_pkg::RS_MODE);
      if (cmd_done) begin
        other_select <= next_cmd[adc_regs_pkg::CMD_RS_LSB +: 3];
        other_read   <= next_cmd[adc_regs_pkg::CMD_RW_BIT];
      end
    end
  end

  // pin shows ready flag outside status and mode reads
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dout_rdy <= 1'b1;
    end else if (state != adc_regs_pkg::ST_READ) begin
      dout_rdy <= rdy;
    end else if (sclk_fall) begin
      // present current top bit on falling edge
      dout_rdy <= shift[15];
    end
  end

  // Pin is driven only while selected, so several devices may share the line
  assign dout_rdy_oe = ~cs_n;

  // ready flag; a set beats a clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdy <= 1'b1;
    end else if (rdy_set) begin
      rdy <= 1'b1;
    end else if (result_load) begin
      rdy <= 1'b0;
    end
  end

  // error flag; a fresh result wins over a clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err <= 1'b0;
    end else if (result_load) begin
      err <= result_clamped;
    end else if (mode_write_stb) begin
      err <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_channel_field <= 3'h0;
    end else begin
      active_channel_field <= converter_channel;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      operating_mode_field <= adc_regs_pkg::MODE_RESET[15:adc_regs_pkg::MODE_OP_LSB];
      clock_source_field   <= adc_regs_pkg::MODE_RESET[adc_regs_pkg::MODE_CLK_LSB +: 2];
      update_rate_field    <= adc_regs_pkg::MODE_RESET[adc_regs_pkg::MODE_RATE_LSB +: 4];
    end else if (mode_write_stb) begin
      operating_mode_field <= write_word[15:adc_regs_pkg::MODE_OP_LSB];
      clock_source_field   <= write_word[adc_regs_pkg::MODE_CLK_LSB +: 2];
      update_rate_field    <= write_word[adc_regs_pkg::MODE_RATE_LSB +: 4];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filter_reset    <= 1'b0;
      continuous_mode <= 1'b1;
      power_down      <= 1'b0;
    end else begin
      filter_reset    <= mode_write_stb;
      continuous_mode <= (operating_mode_field == adc_regs_pkg::OP_CONTINUOUS);
      power_down      <= (operating_mode_field == adc_regs_pkg::OP_POWER_DOWN);
    end
  end

  conv_clock_gen u_conv_clock_gen (
    .clk                (clk),
    .rst                (rst),
    .clock_source_field (clock_source_field),
    .clk_pin_in         (clk_pin_in),
    .conv_tick          (conv_tick),
    .clk_pin_out        (clk_pin_out),
    .clk_pin_oe         (clk_pin_oe)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_status_cmd;
    cmd_done && !next_cmd[7] && next_cmd[adc_regs_pkg::CMD_RW_BIT] &&
      (next_cmd[adc_regs_pkg::CMD_RS_LSB +: 3] == adc_regs_pkg::RS_STATUS);
  endsequence

  sequence s_mode_write;
    mode_write_stb && !result_load;
  endsequence

  a_status_load: assert property (s_status_cmd |=>
    state == adc_regs_pkg::ST_READ && shift[15:8] == $past(status_word))
    else $error("status read did not load status byte");

  a_msb_first_out: assert property (
    (state == adc_regs_pkg::ST_READ && !cs_n && sclk_fall) |=> dout_rdy == $past(shift[15]))
    else $error("read bit not taken from top of shifter");

  a_ready_clear: assert property (
    (result_load && !rdy_set) |=> !rdy)
    else $error("ready not cleared on new result");

  a_ready_set: assert property (
    (data_read_done || pre_update) |=> rdy)
    else $error("ready not set after read or before update");

  a_powerdown_ready: assert property (
    pd_enter |=> rdy ##1 power_down)
    else $error("power-down entry did not set ready");

  a_pin_ready: assert property (
    (state != adc_regs_pkg::ST_READ) ##1 (state != adc_regs_pkg::ST_READ) |->
      dout_rdy == $past(status_word[adc_regs_pkg::ST_RDY_BIT]))
    else $error("data-out pin does not follow ready");

  a_error_update: assert property (
    result_load |=> err == $past(result_clamped) && rdy == $past(rdy_set))
    else $error("error flag not updated with result");

  a_error_clear: assert property (s_mode_write |=> !err)
    else $error("error flag survived mode write");

  a_status_fixed_bits: assert property (
    status_word[5:4] == 2'h0 && status_word[adc_regs_pkg::ST_VAR_BIT] == wide_variant)
    else $error("fixed status bits wrong");

  a_mode_write_effect: assert property (mode_write_stb |=>
    mode_word == ($past(write_word) & adc_regs_pkg::MODE_KEEP) && filter_reset && rdy)
    else $error("mode write effects missing");
endmodule

// ### host_serial_model.sv
// Host serial master model that drives the register port of the converter
`timescale 1ns/1ps
module host_serial_model (
  input  wire logic clk,
  input  wire logic dout_rdy,
  output logic      sclk,
  output logic      cs_n,
  output logic      din
);
  // Idle frame: clock high, chip deselected
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b1;
  end

  // Each serial level lasts 4 clocks, twice the minimum, for margin
  task automatic wait_half();
    repeat (4) @(posedge clk);
    #2;
  endtask

  task automatic shift(input logic [15:0] wd, input int n, output logic [15:0] rd);
    rd = 16'h0000;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0;
      din  = wd[i];
      wait_half();
      rd   = {rd[14:0], dout_rdy}; // Read bit settled long before the rise
      sclk = 1'b1;
      wait_half();
    end
  endtask

  task automatic access(input logic [15:0] cmd, input int nc, input logic [15:0] wd,
                        input int nd, output logic [15:0] rd);
    logic [15:0] junk;
    rd   = 16'h0000;
    cs_n = 1'b0;
    wait_half();
    shift(cmd, nc, junk);
    if (nd > 0) begin
      shift(wd, nd, rd);
    end
    cs_n = 1'b1;
    din  = ~din; // Released line must not keep the last value
    wait_half();
  endtask
endmodule

// ### tb_adc_status_mode_registers.sv
// Self-checking testbench for the converter status and mode register bank
`timescale 1ns/1ps
module tb_adc_status_mode_registers;
  logic        clk, rst, sclk, cs_n, din, dout_rdy, dout_rdy_oe;
  logic        clk_pin_in, clk_pin_out, clk_pin_oe, result_load, result_clamped;
  logic        pre_update, data_read_done, pass_done, other_access, other_read;
  logic        continuous_mode, power_down, filter_reset, conv_tick;
  logic [2:0]  converter_channel, other_select, operating_mode_field;
  logic [1:0]  clock_source_field;
  logic [3:0]  update_rate_field;
  logic [15:0] rd;
  int          errors = 0;
  int          cmp_count = 0;
  int          ticks = 0;
  int          resets = 0;
  int          others = 0;
  int          pin_high = 0;
  int          oe_bad = 0;

  adc_status_mode_registers u_dut (
    .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din), .dout_rdy(dout_rdy),
    .dout_rdy_oe(dout_rdy_oe), .clk_pin_in(clk_pin_in), .clk_pin_out(clk_pin_out),
    .clk_pin_oe(clk_pin_oe), .result_load(result_load), .result_clamped(result_clamped),
    .pre_update(pre_update), .data_read_done(data_read_done),
    .converter_channel(converter_channel), .pass_done(pass_done),
    .other_access(other_access), .other_select(other_select), .other_read(other_read),
    .operating_mode_field(operating_mode_field), .clock_source_field(clock_source_field),
    .update_rate_field(update_rate_field), .continuous_mode(continuous_mode),
    .power_down(power_down), .filter_reset(filter_reset), .conv_tick(conv_tick)
  );

  host_serial_model u_host (
    .clk(clk), .dout_rdy(dout_rdy), .sclk(sclk), .cs_n(cs_n), .din(din)
  );

  // 25 MHz clock
  initial clk = 1'b0;
  always #20 clk = ~clk;

  // Pulse counters, so single-cycle outputs are never missed
  always @(posedge clk) begin
    if (conv_tick === 1'b1) ticks <= ticks + 1;
    if (filter_reset === 1'b1) resets <= resets + 1;
    if (other_access === 1'b1) others <= others + 1;
    if (clk_pin_out === 1'b1) pin_high <= pin_high + 1;
    // Output enable must follow chip select at every edge, selected or not
    if (dout_rdy_oe !== ~cs_n) oe_bad <= oe_bad + 1;
  end

  task automatic clkn(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One-cycle converter events
  task automatic ev(input logic ld, input logic pu, input logic rdd);
    result_load    = ld;
    pre_update     = pu;
    data_read_done = rdd;
    clkn(1);
    {result_load, pre_update, data_read_done} = 3'h0;
    clkn(2);
  endtask

  task automatic rd_status();
    u_host.access(16'h0040, 8, 16'h0000, 8, rd);
  endtask

  task automatic wr_mode(input logic [15:0] v);
    u_host.access(16'h0008, 8, v, 16, rd);
    clkn(2);
  endtask

  task automatic t_reset_values();
    rd_status();
    chk("status", {8'h00, adc_regs_pkg::STATUS_RESET_NARROW}, rd);
    // Leading one ahead of the start bit is skipped
    u_host.access(16'h0148, 9, 16'h0000, 16, rd);
    chk("mode", adc_regs_pkg::MODE_RESET, rd);
    chk("op", 16'h0000, operating_mode_field);
    chk("clksrc", 16'h0000, clock_source_field);
    chk("contin", 16'h0001, continuous_mode);
    chk("clk_oe", 16'h0000, clk_pin_oe);
  endtask

  task automatic t_result_flags();
    converter_channel = 3'h5;
    result_clamped    = 1'b1;
    ev(1'b1, 1'b0, 1'b0);
    chk("ready_pin", 16'h0000, dout_rdy);
    rd_status();
    chk("status", 16'h0045, rd);
    ev(1'b0, 1'b0, 1'b1);
    chk("ready_pin", 16'h0001, dout_rdy);
    rd_status();
    chk("ready", 16'h0001, rd[7]);
    result_clamped = 1'b0;
    ev(1'b1, 1'b0, 1'b0);
    rd_status();
    chk("status", 16'h0005, rd);
    ev(1'b0, 1'b1, 1'b0);
    rd_status();
    chk("ready", 16'h0001, rd[7]);
  endtask

  task automatic t_other_select();
    int n;
    n = others;
    u_host.access(16'h0050, 8, 16'h0000, 0, rd);
    chk("other_access", n + 1, others);
    chk("other_select", 16'h0002, other_select);
    chk("other_read", 16'h0001, other_read);
    pass_done = 1'b1;
    clkn(1);
    pass_done = 1'b0;
    rd_status();
    chk("status", 16'h0085, rd);
  endtask

  task automatic t_mode_write();
    int n;
    result_clamped = 1'b1;
    ev(1'b1, 1'b0, 1'b0);
    n = resets;
    // Power-down, clock driven out, rate 5; reserved bits zero
    wr_mode(16'h6045);
    chk("filter_reset", n + 1, resets);
    rd_status();
    chk("status", 16'h0085, rd);
    u_host.access(16'h0048, 8, 16'h0000, 16, rd);
    chk("mode", 16'h6045, rd);
    chk("op", adc_regs_pkg::OP_POWER_DOWN, operating_mode_field);
    chk("power_down", 16'h0001, power_down);
    chk("contin", 16'h0000, continuous_mode);
    chk("rate", 16'h0005, update_rate_field);
    chk("clk_oe", 16'h0001, clk_pin_oe);
  endtask

  task automatic ext_rises(input int n);
    repeat (n) begin
      clk_pin_in = 1'b1;
      clkn(4);
      clk_pin_in = 1'b0;
      clkn(4);
    end
  endtask

  task automatic t_clock_sources();
    int n;
    int h;
    wr_mode(16'h0000);
    chk("clk_oe", 16'h0000, clk_pin_oe);
    n = ticks;
    clkn(780);
    chk("int_ticks", n + 2, ticks);
    // Driven-out clock: one tick and half a period high per divider period
    wr_mode(16'h0040);
    chk("clk_oe", 16'h0001, clk_pin_oe);
    n = ticks;
    h = pin_high;
    clkn(adc_regs_pkg::CONV_DIV_CYCLES);
    chk("out_ticks", n + 1, ticks);
    chk("pin_high", h + adc_regs_pkg::CONV_DIV_HALF, pin_high);
    wr_mode(16'h0080);
    chk("clk_oe", 16'h0000, clk_pin_oe);
    n = ticks;
    ext_rises(4);
    chk("ext_ticks", n + 4, ticks);
    wr_mode(16'h00c0);
    n = ticks;
    ext_rises(4);
    chk("div_ticks", n + 2, ticks);
    chk("oe_follow", 16'h0000, oe_bad);
  endtask

  task automatic final_report();
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    {result_load, result_clamped, pre_update, data_read_done, pass_done} = 5'h00;
    converter_channel = 3'h0;
    clk_pin_in = 1'b0;
    repeat (5) @(posedge clk);
    #2;
    rst = 1'b0;
    clkn(2);
    t_reset_values();
    t_result_flags();
    t_other_select();
    t_mode_write();
    t_clock_sources();
    final_report();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    final_report();
  end
endmodule
